//--- pkg/dac_regmap_pkg.sv
package dac_regmap_pkg;

	localparam int DEFAULT_RES_BITS = 12;
	localparam int DEFAULT_CHANNELS = 2;
	localparam int WORD_BITS = 16;
	localparam int ADDR_BITS = 5;
	localparam int NV_WORDS = 5;
	localparam int LOCK_BITS = 5;
	localparam int BUS_ADDR_BITS = 7;
	localparam int GAIN_BITS = 2;

	// Volatile area
	localparam logic [4:0] ADDR_CHAN0 = 5'h00;
	localparam logic [4:0] ADDR_CHAN1 = 5'h01;
	localparam logic [4:0] ADDR_REFERENCE = 5'h08;
	localparam logic [4:0] ADDR_POWER_DOWN = 5'h09;
	localparam logic [4:0] ADDR_GAIN_STATUS = 5'h0a;
	localparam logic [4:0] ADDR_LOCK_STATUS = 5'h0b;
	// Nonvolatile area
	localparam logic [4:0] ADDR_NV_CHAN0 = 5'h10;
	localparam logic [4:0] ADDR_NV_CHAN1 = 5'h11;
	localparam logic [4:0] ADDR_NV_REFERENCE = 5'h18;
	localparam logic [4:0] ADDR_NV_POWER_DOWN = 5'h19;
	localparam logic [4:0] ADDR_NV_GAIN_BUS = 5'h1a;
	localparam logic [4:0] RESET_POINTER = 5'h00;

	// Index of each word inside the EEPROM array
	localparam logic [2:0] NV_IDX_CHAN0 = 3'h0;
	localparam logic [2:0] NV_IDX_CHAN1 = 3'h1;
	localparam logic [2:0] NV_IDX_REFERENCE = 3'h2;
	localparam logic [2:0] NV_IDX_POWER_DOWN = 3'h3;
	localparam logic [2:0] NV_IDX_GAIN_BUS = 3'h4;

	// Configuration bits kept outside the map
	localparam logic [2:0] LOCK_IDX_CHAN0_VOL = 3'h0;
	localparam logic [2:0] LOCK_IDX_CHAN0_NV = 3'h1;
	localparam logic [2:0] LOCK_IDX_CHAN1_VOL = 3'h2;
	localparam logic [2:0] LOCK_IDX_CHAN1_NV = 3'h3;
	localparam logic [2:0] LOCK_IDX_BUS_ADDR = 3'h4;
	localparam logic [4:0] FACTORY_LOCKS = 5'h10;

	localparam logic [15:0] RESET_ZERO = 16'h0000;
	localparam logic [15:0] RESET_GAIN_STATUS = 16'h0080;
	localparam logic [15:0] FACTORY_GAIN_BUS = 16'h00e0;
	localparam int STATUS_POR_BIT = 7;
	localparam int STATUS_BUSY_BIT = 6;
	localparam int GAIN_LSB = 8;
	localparam int BUS_ADDR_LSB = 0;

	// EEPROM program cycle
	localparam int CLK_PERIOD_NS = 20;
	localparam int PROGRAM_TIME_NS = 25000000;
	localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {CMD_READ, CMD_WRITE, CMD_HV_ENABLE, CMD_HV_DISABLE} cmd_kind_type;

	typedef struct packed {
		cmd_kind_type kind;
		logic [4:0] addr;
		logic [15:0] data;
	} cmd_type;

	typedef struct packed {
		logic nack;
		logic [15:0] data;
	} resp_type;

	typedef struct packed {
		logic implemented;
		logic is_nv;
		logic [2:0] nv_idx;
		logic hv_target;
		logic [2:0] lock_idx;
	} decode_type;

endpackage : dac_regmap_pkg

//--- core/cmd_decode.sv
`timescale 1ns/10ps
module cmd_decode
	import dac_regmap_pkg::*;
#(
	parameter int CHANNELS = DEFAULT_CHANNELS
)
(
	input wire logic [4:0] addr,
	output decode_type dec
);

	always_comb
	begin
		dec = '0;
		unique case (addr)
			ADDR_CHAN0:
			begin
				dec.implemented = 1'b1;
				dec.hv_target = 1'b1;
				dec.lock_idx = LOCK_IDX_CHAN0_VOL;
			end
			ADDR_CHAN1:
			begin
				dec.implemented = (CHANNELS == 2);
				dec.hv_target = (CHANNELS == 2);
				dec.lock_idx = LOCK_IDX_CHAN1_VOL;
			end
			ADDR_REFERENCE, ADDR_POWER_DOWN, ADDR_GAIN_STATUS, ADDR_LOCK_STATUS:
				dec.implemented = 1'b1;
			ADDR_NV_CHAN0:
			begin
				dec.implemented = 1'b1;
				dec.is_nv = 1'b1;
				dec.nv_idx = NV_IDX_CHAN0;
				dec.hv_target = 1'b1;
				dec.lock_idx = LOCK_IDX_CHAN0_NV;
			end
			ADDR_NV_CHAN1:
			begin
				dec.implemented = (CHANNELS == 2);
				dec.is_nv = 1'b1;
				dec.nv_idx = NV_IDX_CHAN1;
				dec.hv_target = (CHANNELS == 2);
				dec.lock_idx = LOCK_IDX_CHAN1_NV;
			end
			ADDR_NV_REFERENCE:
			begin
				dec.implemented = 1'b1;
				dec.is_nv = 1'b1;
				dec.nv_idx = NV_IDX_REFERENCE;
			end
			ADDR_NV_POWER_DOWN:
			begin
				dec.implemented = 1'b1;
				dec.is_nv = 1'b1;
				dec.nv_idx = NV_IDX_POWER_DOWN;
			end
			ADDR_NV_GAIN_BUS:
			begin
				dec.implemented = 1'b1;
				dec.is_nv = 1'b1;
				dec.nv_idx = NV_IDX_GAIN_BUS;
				dec.hv_target = 1'b1;
				dec.lock_idx = LOCK_IDX_BUS_ADDR;
			end
			default:
				dec = '0;
		endcase
	end

endmodule : cmd_decode

//--- core/eeprom_array.sv
`timescale 1ns/10ps
module eeprom_array
	import dac_regmap_pkg::*;
#(
	parameter int RES_BITS = DEFAULT_RES_BITS,
	parameter int PROG_CYCLES = PROGRAM_CYCLES
)
(
	input wire logic clk,
	input wire logic nv_rst,
	input wire logic ce,
	input wire logic prog_word,
	input wire logic [2:0] prog_idx,
	input wire logic [15:0] prog_data,
	input wire logic prog_lock,
	input wire logic [2:0] lock_idx,
	input wire logic lock_value,
	output logic busy,
	output logic [NV_WORDS-1:0][15:0] words,
	output logic [LOCK_BITS-1:0] locks
);

	localparam logic [15:0] MID_SCALE = 16'((32'h1 << (RES_BITS - 1)) - 1);
	localparam logic [31:0] LAST_COUNT = 32'(PROG_CYCLES - 1);

	logic [31:0] prog_count;

	if (PROG_CYCLES < 1)
		$error("eeprom_array: program cycle count must be at least one");

	// Factory contents are loaded only by the array's own reset, never by power-up
	always_ff @(posedge clk or posedge nv_rst)
	begin
		if (nv_rst)
		begin
			words[NV_IDX_CHAN0] <= MID_SCALE;
			words[NV_IDX_CHAN1] <= MID_SCALE;
			words[NV_IDX_REFERENCE] <= RESET_ZERO;
			words[NV_IDX_POWER_DOWN] <= RESET_ZERO;
			words[NV_IDX_GAIN_BUS] <= FACTORY_GAIN_BUS;
		end
		else if (ce && prog_word && !busy)
			words[prog_idx] <= prog_data;
	end

	always_ff @(posedge clk or posedge nv_rst)
	begin
		if (nv_rst)
			locks <= FACTORY_LOCKS;
		else if (ce && prog_lock && !busy)
			locks[lock_idx] <= lock_value;
	end

	// Busy spans the whole program cycle so a second write cannot tear the cell
	always_ff @(posedge clk or posedge nv_rst)
	begin
		if (nv_rst)
		begin
			busy <= 1'b0;
			prog_count <= '0;
		end
		else if (ce)
		begin
			if (!busy && (prog_word || prog_lock))
			begin
				busy <= 1'b1;
				prog_count <= '0;
			end
			else if (busy && prog_count == LAST_COUNT)
				busy <= 1'b0;
			else if (busy)
				prog_count <= prog_count + 32'h1;
		end
	end

endmodule : eeprom_array

//--- core/dac_nv_register_map.sv
`timescale 1ns/10ps
// How it works
// - Each power-up copies the channel, reference and power-down words and the gain field into their volatile registers.
// - EEPROM programming starts on the completing write command strobe.
// - Nonvolatile writes never touch the volatile copies.
// - Nonvolatile words live at 10h, 11h, 18h, 19h, 1Ah; the rest are reserved.
// - Volatile words live at 00h, 01h, 08h-0Bh; status resets to 0080h.
// - Lock bits change only through high-voltage enable or disable commands.
// - Five configuration bits sit outside the map: two per channel, one address protect.
// - Lock status register reads back the per-channel lock bits.
// - Channel, status and lock registers read unused bit positions as zero; reference, power-down and gain/bus words read all sixteen bits.
// - Normal commands to reserved addresses are refused with a not-acknowledge.
// - Reserved reads not-acknowledge and return all ones at output resolution.
// - High-voltage commands to unimplemented configuration bits are refused.
// - Factory defaults: outputs at mid-scale, reference and power-down zero.
// - Factory bus address is 110 0000 with address protect set.
// - Every location is sixteen bits, output values right-justified.
// - Power-on reset forces the memory pointer to 00h.
module dac_nv_register_map
	import dac_regmap_pkg::*;
#(
	parameter int RES_BITS = DEFAULT_RES_BITS,
	parameter int CHANNELS = DEFAULT_CHANNELS,
	parameter int PROG_CYCLES = PROGRAM_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic nv_rst,
	input wire logic ce,
	input wire logic high_voltage_command_pin,
	input wire logic start_cond,
	input wire logic cmd_valid,
	input cmd_type cmd,
	output logic cmd_ready,
	output logic resp_valid,
	output resp_type resp,
	output logic [15:0] chan0_value,
	output logic [15:0] chan1_value,
	output logic [15:0] reference_value,
	output logic [15:0] power_down_value,
	output logic [GAIN_BITS-1:0] gain_value,
	output logic [BUS_ADDR_BITS-1:0] bus_address,
	output logic eeprom_busy,
	output logic [4:0] mem_pointer
);

	localparam logic [15:0] VALUE_MASK = 16'((32'h1 << RES_BITS) - 1);

	typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_ERROR} state_type;

	state_type state;
	decode_type dec;
	logic hv_meta;
	logic hv_sync;
	logic [NV_WORDS-1:0][15:0] nv_words;
	logic [LOCK_BITS-1:0] locks;
	logic [15:0] chan0_reg;
	logic [15:0] chan1_reg;
	logic [15:0] reference_reg;
	logic [15:0] power_down_reg;
	logic [GAIN_BITS-1:0] gain_reg;
	logic por_flag;
	logic accept;
	logic is_read;
	logic is_write;
	logic is_hv;
	logic next_nack;
	logic [15:0] next_data;
	logic vol_write;
	logic prog_word;
	logic prog_lock;
	logic chan_vol_locked;
	logic chan_nv_locked;

	if (!(RES_BITS == 8 || RES_BITS == 10 || RES_BITS == 12))
		$error("dac_nv_register_map: resolution must be 8, 10 or 12 bits");
	if (!(CHANNELS == 1 || CHANNELS == 2))
		$error("dac_nv_register_map: one or two channels only");

	cmd_decode #(
		.CHANNELS(CHANNELS)
	) u_decode (
		.addr(cmd.addr),
		.dec(dec)
	);

	eeprom_array #(
		.RES_BITS(RES_BITS),
		.PROG_CYCLES(PROG_CYCLES)
	) u_eeprom (
		.clk(clk),
		.nv_rst(nv_rst),
		.ce(ce),
		.prog_word(prog_word),
		.prog_idx(dec.nv_idx),
		.prog_data(cmd.data),
		.prog_lock(prog_lock),
		.lock_idx(dec.lock_idx),
		.lock_value(cmd.kind == CMD_HV_ENABLE),
		.busy(eeprom_busy),
		.words(nv_words),
		.locks(locks)
	);

	// High-voltage level arrives straight from a pin
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hv_meta <= 1'b0;
			hv_sync <= 1'b0;
		end
		else if (ce)
		begin
			hv_meta <= high_voltage_command_pin;
			hv_sync <= hv_meta;
		end
	end

	assign cmd_ready = (state == ST_IDLE);
	assign accept = cmd_valid && cmd_ready;
	assign is_read = (cmd.kind == CMD_READ);
	assign is_write = (cmd.kind == CMD_WRITE);
	assign is_hv = (cmd.kind == CMD_HV_ENABLE) || (cmd.kind == CMD_HV_DISABLE);

	// Volatile output is held by the nonvolatile lock; nonvolatile by either bit
	always_comb
	begin
		chan_vol_locked = 1'b0;
		chan_nv_locked = 1'b0;
		if (cmd.addr == ADDR_CHAN0 || cmd.addr == ADDR_NV_CHAN0)
		begin
			chan_vol_locked = locks[LOCK_IDX_CHAN0_NV];
			chan_nv_locked = locks[LOCK_IDX_CHAN0_NV] | locks[LOCK_IDX_CHAN0_VOL];
		end
		else if (cmd.addr == ADDR_CHAN1 || cmd.addr == ADDR_NV_CHAN1)
		begin
			chan_vol_locked = locks[LOCK_IDX_CHAN1_NV];
			chan_nv_locked = locks[LOCK_IDX_CHAN1_NV] | locks[LOCK_IDX_CHAN1_VOL];
		end
		else if (cmd.addr == ADDR_NV_GAIN_BUS)
			chan_nv_locked = locks[LOCK_IDX_BUS_ADDR];
	end

	always_comb
	begin
		next_nack = 1'b0;
		if (is_hv)
			next_nack = !hv_sync || !dec.hv_target || eeprom_busy;
		else if (!dec.implemented)
			next_nack = 1'b1;
		else if (is_write && dec.is_nv)
			next_nack = chan_nv_locked || eeprom_busy;
		else if (is_write)
			next_nack = chan_vol_locked;
	end

	// Read data: right-justified and zero above the field, all ones when reserved
	always_comb
	begin
		next_data = RESET_ZERO;
		unique case (cmd.addr)
			ADDR_CHAN0:
				next_data = chan0_reg & VALUE_MASK;
			ADDR_CHAN1:
				next_data = chan1_reg & VALUE_MASK;
			ADDR_REFERENCE:
				next_data = reference_reg;
			ADDR_POWER_DOWN:
				next_data = power_down_reg;
			ADDR_GAIN_STATUS:
			begin
				next_data[GAIN_LSB +: GAIN_BITS] = gain_reg;
				next_data[STATUS_POR_BIT] = por_flag;
				next_data[STATUS_BUSY_BIT] = eeprom_busy;
			end
			ADDR_LOCK_STATUS:
				next_data[3:0] = locks[3:0];
			ADDR_NV_CHAN0:
				next_data = nv_words[NV_IDX_CHAN0] & VALUE_MASK;
			ADDR_NV_CHAN1:
				next_data = nv_words[NV_IDX_CHAN1] & VALUE_MASK;
			ADDR_NV_REFERENCE:
				next_data = nv_words[NV_IDX_REFERENCE];
			ADDR_NV_POWER_DOWN:
				next_data = nv_words[NV_IDX_POWER_DOWN];
			ADDR_NV_GAIN_BUS:
				next_data = nv_words[NV_IDX_GAIN_BUS];
			default:
				next_data = VALUE_MASK;
		endcase
		if (!dec.implemented)
			next_data = VALUE_MASK;
	end

	assign vol_write = accept && is_write && !next_nack && !dec.is_nv;
	assign prog_word = ce && accept && is_write && !next_nack && dec.is_nv;
	assign prog_lock = ce && accept && is_hv && !next_nack;

	// Bus state: a refusal parks the interface until the master sends a start
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state <= ST_LOAD;
		else if (ce)
		begin
			unique case (state)
				ST_LOAD:
					state <= ST_IDLE;
				ST_IDLE:
					if (accept && next_nack)
						state <= ST_ERROR;
				ST_ERROR:
					if (start_cond)
						state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			mem_pointer <= RESET_POINTER;
		else if (ce && accept)
			mem_pointer <= cmd.addr;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			resp_valid <= 1'b0;
			resp <= '0;
		end
		else if (ce)
		begin
			resp_valid <= accept;
			if (accept)
			begin
				resp.nack <= next_nack;
				resp.data <= is_read ? next_data : RESET_ZERO;
			end
		end
	end

	// Volatile registers: loaded from EEPROM once after power-up, then by writes only
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			chan0_reg <= RESET_ZERO;
			chan1_reg <= RESET_ZERO;
			reference_reg <= RESET_ZERO;
			power_down_reg <= RESET_ZERO;
			gain_reg <= '0;
			por_flag <= RESET_GAIN_STATUS[STATUS_POR_BIT];
		end
		else if (ce && state == ST_LOAD)
		begin
			chan0_reg <= nv_words[NV_IDX_CHAN0] & VALUE_MASK;
			chan1_reg <= nv_words[NV_IDX_CHAN1] & VALUE_MASK;
			reference_reg <= nv_words[NV_IDX_REFERENCE];
			power_down_reg <= nv_words[NV_IDX_POWER_DOWN];
			gain_reg <= nv_words[NV_IDX_GAIN_BUS][GAIN_LSB +: GAIN_BITS];
		end
		else if (ce && vol_write)
		begin
			unique case (cmd.addr)
				ADDR_CHAN0:
					chan0_reg <= cmd.data & VALUE_MASK;
				ADDR_CHAN1:
					chan1_reg <= cmd.data & VALUE_MASK;
				ADDR_REFERENCE:
					reference_reg <= cmd.data;
				ADDR_POWER_DOWN:
					power_down_reg <= cmd.data;
				ADDR_GAIN_STATUS:
					gain_reg <= cmd.data[GAIN_LSB +: GAIN_BITS];
				default:
					gain_reg <= gain_reg; // Lock status is read-only
			endcase
		end
	end

	// Address comes straight from EEPROM, so a new address takes effect at once
	assign bus_address = nv_words[NV_IDX_GAIN_BUS][BUS_ADDR_LSB +: BUS_ADDR_BITS];
	assign chan0_value = chan0_reg;
	assign chan1_value = (CHANNELS == 2) ? chan1_reg : RESET_ZERO;
	assign reference_value = reference_reg;
	assign power_down_value = power_down_reg;
	assign gain_value = gain_reg;

endmodule : dac_nv_register_map

//--- verification/dac_nv_register_map_checker.sv
`timescale 1ns/10ps
module dac_nv_register_map_checker
	import dac_regmap_pkg::*;
#(
	parameter int RES_BITS = DEFAULT_RES_BITS,
	parameter int PROG_CYCLES = PROGRAM_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start_cond,
	input wire logic cmd_valid,
	input cmd_type cmd,
	input wire logic cmd_ready,
	input wire logic resp_valid,
	input resp_type resp,
	input wire logic [15:0] chan0_value,
	input wire logic [15:0] chan1_value,
	input wire logic eeprom_busy,
	input wire logic [4:0] mem_pointer
);
	localparam logic [15:0] MASK = 16'((32'h1 << RES_BITS) - 1);
	wire take = cmd_valid && cmd_ready;
	wire normal = cmd.kind inside {CMD_READ, CMD_WRITE};
	wire nv_write = take && cmd.kind == CMD_WRITE && cmd.addr[4];
	// Dual-channel map assumed
	wire rsv = !(cmd.addr inside {5'h00, 5'h01, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h10, 5'h11, 5'h18, 5'h19, 5'h1a});
	wire lock_addr = cmd.addr inside {5'h00, 5'h01, 5'h10, 5'h11, 5'h1a};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_rsv_nack;
		take && normal && rsv |=> resp_valid && resp.nack;
	endproperty
	a_rsv_nack: assert property (p_rsv_nack) else $error("reserved command acknowledged");
	property p_rsv_ones;
		take && cmd.kind == CMD_READ && rsv |=> resp.data == MASK;
	endproperty
	a_rsv_ones: assert property (p_rsv_ones) else $error("reserved read not all ones");
	property p_nack_hold;
		resp_valid && resp.nack |-> !cmd_ready [*2];
	endproperty
	a_nack_hold: assert property (p_nack_hold) else $error("ready before start condition");
	property p_hv_rsv;
		take && !normal && !lock_addr |=> resp.nack;
	endproperty
	a_hv_rsv: assert property (p_hv_rsv) else $error("high-voltage command to no lock bit accepted");
	property p_nv_busy;
		nv_write && eeprom_busy |=> resp.nack;
	endproperty
	a_nv_busy: assert property (p_nv_busy) else $error("write accepted during program cycle");
	property p_prog_start;
		nv_write ##1 !resp.nack |-> eeprom_busy;
	endproperty
	a_prog_start: assert property (p_prog_start) else $error("program cycle did not start");
	property p_nv_vol;
		nv_write |=> $stable(chan0_value) && $stable(chan1_value);
	endproperty
	a_nv_vol: assert property (p_nv_vol) else $error("volatile copy changed by stored write");
	property p_zero_bits;
		take && cmd.kind == CMD_READ && !rsv |=> resp.data[15:12] == 4'h0;
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("unused bits read nonzero");
	property p_ptr_reset;
		$fell(rst) |-> mem_pointer == RESET_POINTER;
	endproperty
	a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not cleared by reset");

	c_nack: cover property (resp_valid && resp.nack);
	c_prog: cover property ($rose(eeprom_busy));
	c_start: cover property (start_cond ##1 cmd_ready);
endmodule : dac_nv_register_map_checker

bind dac_nv_register_map dac_nv_register_map_checker #(.RES_BITS(RES_BITS), .PROG_CYCLES(PROG_CYCLES)) chk (
	.clk(clk), .rst(rst), .start_cond(start_cond), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
	.resp_valid(resp_valid), .resp(resp), .chan0_value(chan0_value), .chan1_value(chan1_value),
	.eeprom_busy(eeprom_busy), .mem_pointer(mem_pointer));

//--- verification/bus_master_model.sv
`timescale 1ns/10ps
module bus_master_model
	import dac_regmap_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_ready,
	input wire logic resp_valid,
	input resp_type resp,
	output logic start_cond,
	output logic cmd_valid,
	output cmd_type cmd
);
	initial
	begin
		start_cond = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// A refused command leaves the slave deaf until a start condition
	always @(posedge clk)
		start_cond <= !rst && resp_valid && resp.nack;

	// Gap makes the master slow on demand; released fields are inverted so no stale value lingers
	task automatic issue(input cmd_kind_type k, input logic [4:0] a, input logic [15:0] d, input int gap);
		int n;
		n = 0;
		repeat (gap) @(posedge clk);
		do
			@(negedge clk);
		while (cmd_ready !== 1'b1 && ++n < 40);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= '{k, a, d};
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd <= '{cmd_kind_type'(~k), ~a, ~d};
	endtask : issue
endmodule : bus_master_model

//--- verification/test_dac_nv_register_map.sv
`timescale 1ns/10ps
module test_dac_nv_register_map
	import dac_regmap_pkg::*;
;
	localparam logic [15:0] MASK = 16'h0fff;
	logic clk, rst, nv_rst, ce, hv_pin, start_cond, cmd_valid, cmd_ready, resp_valid, eeprom_busy;
	cmd_type cmd;
	resp_type resp;
	logic [15:0] chan0_value, chan1_value, reference_value, power_down_value, v0, v1;
	logic [GAIN_BITS-1:0] gain_value;
	logic [BUS_ADDR_BITS-1:0] bus_address;
	logic [4:0] mem_pointer;
	logic [31:0] seed;
	resp_type expect_q [$];
	int mismatches, comparisons, cycles;
	logic [4:0] addrs [11] = '{5'h00, 5'h01, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h10, 5'h11, 5'h18, 5'h19, 5'h1a};
	logic [15:0] dflt [11] = '{16'h07ff, 16'h07ff, 16'h0, 16'h0, 16'h0080, 16'h0, 16'h07ff, 16'h07ff, 16'h0, 16'h0,
		16'h00e0};

	dac_nv_register_map #(.PROG_CYCLES(8)) dut (.clk(clk), .rst(rst), .nv_rst(nv_rst), .ce(ce),
		.high_voltage_command_pin(hv_pin), .start_cond(start_cond), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp(resp), .chan0_value(chan0_value),
		.chan1_value(chan1_value), .reference_value(reference_value), .power_down_value(power_down_value),
		.gain_value(gain_value), .bus_address(bus_address), .eeprom_busy(eeprom_busy), .mem_pointer(mem_pointer));
	bus_master_model m (.clk(clk), .rst(rst), .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp(resp),
		.start_cond(start_cond), .cmd_valid(cmd_valid), .cmd(cmd));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input string name, input logic [16:0] e, input logic [16:0] g);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", name, e, g);
		end
	endtask : check

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	task automatic op(input cmd_kind_type k, input logic [4:0] a, input logic [15:0] d, input logic n,
		input logic [15:0] rd);
		expect_q.push_back('{n, rd});
		m.issue(k, a, d, int'(seed[0]));
		seed = lfsr(seed);
	endtask : op

	task automatic wait_idle();
		@(negedge clk);
		for (int n = 0; n < 40 && eeprom_busy !== 1'b0; n++)
			@(negedge clk);
	endtask : wait_idle

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Responses are matched in order of issue
	always @(negedge clk)
		if (resp_valid === 1'b1)
			check("response", expect_q.size() > 0 ? expect_q.pop_front() : 17'bx, resp);

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			summarize();
		end
	end

	initial
	begin
		rst = 1'b1;
		nv_rst = 1'b1;
		ce = 1'b1;
		hv_pin = 1'b0;
		seed = 32'h086b;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		nv_rst <= 1'b0;
		repeat (2) @(negedge clk);
		check("pointer", 17'(RESET_POINTER), 17'(mem_pointer));
		check("bus address", 17'h60, 17'(bus_address));
		for (int i = 0; i < 11; i++)
			op(CMD_READ, addrs[i], 16'h0, 1'b0, dflt[i]);
		for (int i = 0; i < 32; i++)
			if (!(5'(i) inside {addrs}))
			begin
				op(CMD_READ, 5'(i), 16'h0, 1'b1, MASK);
				op(CMD_WRITE, 5'(i), seed[15:0], 1'b1, 16'h0);
			end
		v0 = seed[15:0];
		v1 = seed[31:16] ^ 16'h0a5a;
		op(CMD_WRITE, ADDR_CHAN0, v0, 1'b0, 16'h0);
		op(CMD_READ, ADDR_CHAN0, 16'h0, 1'b0, v0 & MASK);
		op(CMD_WRITE, ADDR_NV_CHAN0, v1, 1'b0, 16'h0);
		op(CMD_WRITE, ADDR_NV_CHAN1, v1, 1'b1, 16'h0);
		op(CMD_READ, ADDR_NV_CHAN0, 16'h0, 1'b0, v1 & MASK);
		@(negedge clk);
		check("volatile copy", 17'(v0 & MASK), 17'(chan0_value));
		wait_idle();
		@(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(negedge clk);
		check("pointer", 17'(RESET_POINTER), 17'(mem_pointer));
		check("power-up load", 17'(v1 & MASK), 17'(chan0_value));
		op(CMD_WRITE, ADDR_REFERENCE, v0, 1'b0, 16'h0);
		op(CMD_WRITE, ADDR_POWER_DOWN, v1, 1'b0, 16'h0);
		op(CMD_WRITE, ADDR_GAIN_STATUS, 16'hffff, 1'b0, 16'h0);
		op(CMD_READ, ADDR_GAIN_STATUS, 16'h0, 1'b0, 16'h0380);
		op(CMD_WRITE, ADDR_NV_GAIN_BUS, 16'h0011, 1'b1, 16'h0);
		@(negedge clk);
		check("reference", 17'(v0), 17'(reference_value));
		check("power-down", 17'(v1), 17'(power_down_value));
		check("gain", 17'h3, 17'(gain_value));
		check("protected bus address", 17'h60, 17'(bus_address));
		@(posedge clk);
		hv_pin <= 1'b1;
		repeat (3) @(posedge clk);
		op(CMD_HV_ENABLE, ADDR_NV_CHAN0, 16'h0, 1'b0, 16'h0);
		@(posedge clk);
		ce <= 1'b0;
		repeat (20) @(posedge clk);
		@(negedge clk);
		check("frozen program cycle", 17'h1, 17'(eeprom_busy));
		@(posedge clk);
		ce <= 1'b1;
		wait_idle();
		op(CMD_READ, ADDR_LOCK_STATUS, 16'h0, 1'b0, 16'h0002);
		op(CMD_WRITE, ADDR_CHAN0, v0, 1'b1, 16'h0);
		op(CMD_WRITE, ADDR_LOCK_STATUS, 16'hffff, 1'b0, 16'h0);
		op(CMD_READ, ADDR_LOCK_STATUS, 16'h0, 1'b0, 16'h0002);
		op(CMD_HV_ENABLE, ADDR_REFERENCE, 16'h0, 1'b1, 16'h0);
		op(CMD_HV_DISABLE, ADDR_NV_CHAN0, 16'h0, 1'b0, 16'h0);
		wait_idle();
		op(CMD_READ, ADDR_LOCK_STATUS, 16'h0, 1'b0, 16'h0000);
		@(posedge clk);
		hv_pin <= 1'b0;
		repeat (3) @(posedge clk);
		op(CMD_HV_ENABLE, ADDR_CHAN0, 16'h0, 1'b1, 16'h0);
		repeat (4) @(posedge clk);
		check("queue empty", 17'h0, 17'(expect_q.size()));
		summarize();
	end
endmodule : test_dac_nv_register_map
